// >>> design/mcg_pkg.sv
// Package: constants, register map and carrier types of the clock generator
package mcg_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses on the APB bus)
   // -----------------------------------------------------------------
   localparam logic [11:0] MCG_CGC_OFFSET  = 12'h000; // Clock gen control
   localparam logic [11:0] MCG_SC1_OFFSET  = 12'h004; // System control one
   localparam logic [11:0] MCG_STAT_OFFSET = 12'h008; // Generator status

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int unsigned MCG_CTRL_W      = 15;      // Used control bits
   localparam logic [31:0] MCG_CGC_RESET   = 32'h0000_0000;
   localparam logic [31:0] MCG_SC1_RESET   = 32'h0000_0000;
   localparam int unsigned MCG_HALVE_BIT   = 0;       // In system_control_one
   localparam int unsigned MCG_ST_LOCK_BIT = 0;
   localparam int unsigned MCG_ST_PLL_BIT  = 1;
   localparam int unsigned MCG_ST_RSVD_BIT = 2;
   localparam int unsigned MCG_ST_STATE_LO = 4;
   localparam int unsigned MCG_ST_FW_LO    = 16;

   // -----------------------------------------------------------------
   // Divider limits
   // -----------------------------------------------------------------
   localparam logic [1:0] MCG_IDIV_MAX = 2'h3;  // Input prescale ceiling
   localparam logic [3:0] MCG_ODIV_MAX = 4'hE;  // Output prescale ceiling

   // -----------------------------------------------------------------
   // Loop model: frequency word limits per band, step, lock count
   // -----------------------------------------------------------------
   localparam logic [15:0] MCG_FW_B0_LO = 16'h6666; // 100 of 250 scale
   localparam logic [15:0] MCG_FW_B0_HI = 16'h9999; // 150
   localparam logic [15:0] MCG_FW_B1_HI = 16'hCCCC; // 200
   localparam logic [15:0] MCG_FW_B2_HI = 16'hFFFF; // 250
   localparam logic [15:0] MCG_FW_STEP  = 16'h0010; // Per reference event
   localparam logic [3:0]  MCG_LOCK_CNT = 4'h8;     // Good events to lock

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      MCG_SRC_BYP0 = 2'b00,
      MCG_SRC_BYP1 = 2'b01,
      MCG_SRC_RSVD = 2'b10,
      MCG_SRC_PLL  = 2'b11
   } mcg_src_type;

   typedef enum logic [1:0] {
      MCG_BAND_100 = 2'b00,
      MCG_BAND_150 = 2'b01,
      MCG_BAND_200 = 2'b10,
      MCG_BAND_RSV = 2'b11
   } mcg_band_type;

   typedef enum logic [1:0] {
      MCG_LOOP_OFF  = 2'b00,
      MCG_LOOP_ACQ  = 2'b01,
      MCG_LOOP_LOCK = 2'b10
   } mcg_loop_type;

   // Low bits of clock_generation_control, lsb last
   typedef struct packed {
      logic [4:0]   loop_multiply_factor;
      logic [3:0]   output_prescale_factor;
      logic [1:0]   input_prescale_factor;
      mcg_band_type vco_band_select;
      mcg_src_type  master_clock_source_select;
   } mcg_ctrl_type;

endpackage

// >>> design/mcg_tick_div.sv
// Tick divider: one output pulse per (limit+1) input ticks
`timescale 1ns/100ps
module mcg_tick_div #(
   parameter int unsigned W = 6
) (
   input  wire logic         clk_in,    // Reference clock
   input  wire logic         rst_in,    // Async reset, high
   input  wire logic         clr_in,    // Restart count
   input  wire logic         tick_in,   // Input event
   input  wire logic [W-1:0] limit_in,  // Divide factor minus one
   output logic      [W-1:0] count_out, // Ticks seen in this period
   output logic              tick_out   // One pulse per period
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         tick_q;
   logic         tick_d;

   // Next count; a limit lowered below the count wraps on the next input tick
   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (clr_in) begin
         cnt_d = '0;
      end else if (tick_in) begin
         if (cnt_q >= limit_in) begin
            cnt_d  = '0;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
      end
   end

   // State registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign count_out = cnt_q;
   assign tick_out  = tick_q;
endmodule

// >>> design/mcg_cpu_halve.sv
// CPU clock stage: passes or halves the master clock events
`timescale 1ns/100ps
module mcg_cpu_halve (
   input  wire logic clk_in,    // Reference clock
   input  wire logic rst_in,    // Async reset, high
   input  wire logic halve_in,  // 1: CPU runs at half master rate
   input  wire logic tick_in,   // Master clock event
   input  wire logic level_in,  // Master clock level
   output logic      tick_out,  // CPU clock event
   output logic      level_out  // CPU clock level
);
   logic phase_q;
   logic phase_d;
   logic tick_q;
   logic tick_d;
   logic level_q;
   logic level_d;

   // Every second master event passes when halving
   always_comb begin
      phase_d = phase_q;
      if (!halve_in) begin
         phase_d = 1'b0;
      end else if (tick_in) begin
         phase_d = ~phase_q;
      end
      tick_d  = tick_in & (~halve_in | phase_q);
      level_d = halve_in ? phase_d : level_in;
   end

   // State registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase_q <= 1'b0;
         tick_q  <= 1'b0;
         level_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         tick_q  <= tick_d;
         level_q <= level_d;
      end
   end

   assign tick_out  = tick_q;
   assign level_out = level_q;
endmodule

// >>> design/mcg_top.sv
// Master clock generator: bypass prescalers, loop model, CPU/system clocks
//
// Notes on behaviour
// - Bypass: master = oscillator / ((input factor+1)*(output factor+1))
// - Both factors zero in bypass: master follows oscillator directly
// - Input factor up to 3, output factor up to 14
// - Loop mode: master = osc*(multiply+1)/((input+1)*(output+1))
// - Loop frequency moves in small steps, never jumps
// - One bit picks CPU and bus unit at master rate or half
// - System clock for peripherals equals CPU clock rate
// - Software control field picks bypass or loop generation
// - Band 00 100-150, 01 150-200, 10 200-250 MHz; 11 reserved
// - Loop mode: master is VCO divided by output factor plus one
`timescale 1ns/100ps
module mcg_top
   import mcg_pkg::*;
(
   input  wire logic        REF_CLK_IN,  // 50 MHz reference clock
   input  wire logic        RST_IN,      // Async reset, high
   input  wire logic        OSC_IN,      // Oscillator input pin
   input  wire logic        PSEL_IN,     // APB select
   input  wire logic        PENABLE_IN,  // APB enable
   input  wire logic        PWRITE_IN,   // APB direction
   input  wire logic [11:0] PADDR_IN,    // APB byte address
   input  wire logic [31:0] PWDATA_IN,   // APB write data
   output logic             PREADY_OUT,  // APB ready
   output logic      [31:0] PRDATA_OUT,  // APB read data
   output logic             PSLVERR_OUT, // APB error, unmapped address
   output logic             MC_CLK_OUT,  // Master clock level
   output logic             MC_TICK_OUT, // Master clock event
   output logic             CPU_CLK_OUT, // CPU and bus unit clock level
   output logic             CPU_TICK_OUT,// CPU and bus unit clock event
   output logic             SYS_TICK_OUT,// Peripheral system clock event
   output logic             LOCK_OUT     // Loop locked
);

   // -----------------------------------------------------------------
   // Oscillator pin synchroniser and edge detect
   // -----------------------------------------------------------------
   logic osc_meta_q;
   logic osc_sync_q;
   logic osc_prev_q;
   logic osc_rise;

   // Two stages before any logic looks at the pin
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_meta_q <= OSC_IN;
         osc_sync_q <= osc_meta_q;
         osc_prev_q <= osc_sync_q;
      end
   end

   assign osc_rise = osc_sync_q & ~osc_prev_q;

   // -----------------------------------------------------------------
   // Register file over APB
   // -----------------------------------------------------------------
   mcg_ctrl_type ctrl_q;
   mcg_ctrl_type ctrl_d;
   logic         halve_q;
   logic         halve_d;
   logic         pready_q;
   logic         pready_d;
   logic [31:0]  prdata_q;
   logic [31:0]  prdata_d;
   logic         pslverr_q;
   logic         pslverr_d;
   logic [31:0]  status_word;
   logic         apb_take;
   logic         mapped;
   mcg_loop_type loop_q;
   logic [15:0]  fw_q;
   logic         rsvd_band;
   logic         pll_mode;

   assign apb_take = PSEL_IN & PENABLE_IN & pready_q;
   assign mapped   = (PADDR_IN == MCG_CGC_OFFSET) |
                     (PADDR_IN == MCG_SC1_OFFSET) |
                     (PADDR_IN == MCG_STAT_OFFSET);

   // Status word shows the loop's own state
   always_comb begin
      status_word                  = '0;
      status_word[MCG_ST_LOCK_BIT] = (loop_q == MCG_LOOP_LOCK);
      status_word[MCG_ST_PLL_BIT]  = pll_mode;
      status_word[MCG_ST_RSVD_BIT] = rsvd_band;
      status_word[MCG_ST_STATE_LO +: 2] = loop_q;
      status_word[MCG_ST_FW_LO +: 16]   = fw_q;
   end

   // One wait state: ready rises in the second access cycle
   always_comb begin
      ctrl_d    = ctrl_q;
      halve_d   = halve_q;
      pready_d  = PSEL_IN & PENABLE_IN & ~pready_q;
      prdata_d  = '0;
      pslverr_d = PSEL_IN & PENABLE_IN & ~pready_q & ~mapped;
      if (PSEL_IN && PENABLE_IN && !pready_q && !PWRITE_IN) begin
         unique case (PADDR_IN)
            MCG_CGC_OFFSET:  prdata_d = {17'h0_0000, ctrl_q};
            MCG_SC1_OFFSET:  prdata_d = {31'h0000_0000, halve_q};
            MCG_STAT_OFFSET: prdata_d = status_word;
            default:         prdata_d = '0;
         endcase
      end
      if (apb_take && PWRITE_IN) begin
         if (PADDR_IN == MCG_CGC_OFFSET) begin
            ctrl_d = mcg_ctrl_type'(PWDATA_IN[MCG_CTRL_W-1:0]);
            // Output factor above 14 is held at 14
            if (PWDATA_IN[9:6] > MCG_ODIV_MAX) begin
               ctrl_d.output_prescale_factor = MCG_ODIV_MAX;
            end
         end
         if (PADDR_IN == MCG_SC1_OFFSET) begin
            halve_d = PWDATA_IN[MCG_HALVE_BIT];
         end
      end
   end

   // Register file state
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctrl_q    <= mcg_ctrl_type'(MCG_CGC_RESET[MCG_CTRL_W-1:0]);
         halve_q   <= MCG_SC1_RESET[MCG_HALVE_BIT];
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         halve_q   <= halve_d;
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // -----------------------------------------------------------------
   // Bypass path: both prescalers as one divider of their product
   // -----------------------------------------------------------------
   logic [5:0] byp_limit;
   logic [5:0] byp_half;
   logic [5:0] byp_count;
   logic       byp_tick;
   logic       byp_level;
   logic       byp_direct;

   assign pll_mode  = (ctrl_q.master_clock_source_select == MCG_SRC_PLL);
   // Product of the two factors, at most 4 x 15 = 60
   assign byp_limit = 6'((ctrl_q.input_prescale_factor + 3'd1) *
                     (ctrl_q.output_prescale_factor + 5'd1) - 1);
   assign byp_half   = 6'((7'(byp_limit) + 7'd2) >> 1);
   assign byp_direct = (byp_limit == 6'h00);
   assign byp_level  = byp_direct ? osc_sync_q
                                  : (byp_count < byp_half);

   mcg_tick_div #(.W(6)) u_byp_div (
      .clk_in    (REF_CLK_IN),
      .rst_in    (RST_IN),
      .clr_in    (pll_mode),
      .tick_in   (osc_rise),
      .limit_in  (byp_limit),
      .count_out (byp_count),
      .tick_out  (byp_tick)
   );

   // -----------------------------------------------------------------
   // Loop path: reference prescaler, VCO model, feedback compare
   // -----------------------------------------------------------------
   logic         ref_evt;
   logic         loop_run;
   mcg_loop_type loop_d;
   logic [15:0]  fw_d;
   logic [15:0]  acc_q;
   logic [15:0]  acc_d;
   logic         vco_tick;
   logic [6:0]   vco_cnt_q;
   logic [6:0]   vco_cnt_d;
   logic [6:0]   vco_seen;
   logic [6:0]   vco_target;
   logic [3:0]   good_q;
   logic [3:0]   good_d;
   logic [15:0]  band_lo;
   logic [15:0]  band_hi;
   logic [3:0]   pll_count;
   logic         pll_tick;
   logic         pll_level;

   assign rsvd_band = (ctrl_q.vco_band_select == MCG_BAND_RSV);
   assign loop_run  = pll_mode & ~rsvd_band;

   // Frequency word window of each band; reserved band stops the loop
   always_comb begin
      unique case (ctrl_q.vco_band_select)
         MCG_BAND_100: begin
            band_lo = MCG_FW_B0_LO;
            band_hi = MCG_FW_B0_HI;
         end
         MCG_BAND_150: begin
            band_lo = MCG_FW_B0_HI;
            band_hi = MCG_FW_B1_HI;
         end
         MCG_BAND_200: begin
            band_lo = MCG_FW_B1_HI;
            band_hi = MCG_FW_B2_HI;
         end
         MCG_BAND_RSV: begin
            band_lo = MCG_FW_B0_LO;
            band_hi = MCG_FW_B0_LO;
         end
      endcase
   end

   mcg_tick_div #(.W(2)) u_ref_div (
      .clk_in    (REF_CLK_IN),
      .rst_in    (RST_IN),
      .clr_in    (~loop_run),
      .tick_in   (osc_rise),
      .limit_in  (ctrl_q.input_prescale_factor),
      .count_out (),
      .tick_out  (ref_evt)
   );

   // Phase accumulator: carry out is one VCO period
   assign {vco_tick, acc_d} = loop_run ? (17'(acc_q) + 17'(fw_q))
                                       : 17'h0_0000;
   assign vco_seen   = vco_cnt_q + 7'(vco_tick);
   assign vco_target = 7'(ctrl_q.loop_multiply_factor) + 7'd1;

   // Loop control: word moves one step per reference event only
   always_comb begin
      loop_d    = loop_q;
      fw_d      = fw_q;
      good_d    = good_q;
      vco_cnt_d = vco_seen;
      if (!loop_run) begin
         loop_d    = MCG_LOOP_OFF;
         fw_d      = band_lo;
         good_d    = '0;
         vco_cnt_d = '0;
      end else begin
         unique case (loop_q)
            MCG_LOOP_OFF: begin
               loop_d = MCG_LOOP_ACQ;
               fw_d   = band_lo;
            end
            MCG_LOOP_ACQ, MCG_LOOP_LOCK: begin
               if (ref_evt) begin
                  vco_cnt_d = '0;
                  if (vco_seen < vco_target) begin
                     fw_d   = (fw_q > band_hi - MCG_FW_STEP) ? band_hi
                              : fw_q + MCG_FW_STEP;
                     good_d = '0;
                  end else if (vco_seen > vco_target) begin
                     fw_d   = (fw_q < band_lo + MCG_FW_STEP) ? band_lo
                              : fw_q - MCG_FW_STEP;
                     good_d = '0;
                  end else if (good_q != MCG_LOCK_CNT) begin
                     good_d = good_q + 4'd1;
                  end
                  loop_d = (good_d == MCG_LOCK_CNT) ? MCG_LOOP_LOCK
                                                    : MCG_LOOP_ACQ;
               end
            end
            default: begin
               loop_d = MCG_LOOP_OFF;
            end
         endcase
      end
   end

   // Loop state
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         loop_q    <= MCG_LOOP_OFF;
         fw_q      <= MCG_FW_B0_LO;
         acc_q     <= '0;
         vco_cnt_q <= '0;
         good_q    <= '0;
      end else begin
         loop_q    <= loop_d;
         fw_q      <= fw_d;
         acc_q     <= acc_d;
         vco_cnt_q <= vco_cnt_d;
         good_q    <= good_d;
      end
   end

   // Output prescaler divides the VCO events down to master rate
   mcg_tick_div #(.W(4)) u_out_div (
      .clk_in    (REF_CLK_IN),
      .rst_in    (RST_IN),
      .clr_in    (~loop_run),
      .tick_in   (vco_tick),
      .limit_in  (ctrl_q.output_prescale_factor),
      .count_out (pll_count),
      .tick_out  (pll_tick)
   );

   assign pll_level = (ctrl_q.output_prescale_factor == 4'h0) ? acc_q[15]
      : (pll_count < 4'((5'(ctrl_q.output_prescale_factor) + 5'd2) >> 1));

   // -----------------------------------------------------------------
   // Master clock selection and CPU / system clocks
   // -----------------------------------------------------------------
   logic mc_tick_q;
   logic mc_tick_d;
   logic mc_level_q;
   logic mc_level_d;
   logic lock_q;
   logic cpu_tick;
   logic cpu_level;
   logic sys_tick_q;

   // Source switch is immediate; a short period can occur at the swap
   always_comb begin
      mc_tick_d  = pll_mode ? pll_tick : byp_tick;
      mc_level_d = pll_mode ? (loop_run & pll_level)
                            : byp_level;
   end

   // Master clock registers
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         mc_tick_q  <= 1'b0;
         mc_level_q <= 1'b0;
         lock_q     <= 1'b0;
         sys_tick_q <= 1'b0;
      end else begin
         mc_tick_q  <= mc_tick_d;
         mc_level_q <= mc_level_d;
         lock_q     <= (loop_q == MCG_LOOP_LOCK);
         sys_tick_q <= mc_tick_d & (~halve_q | cpu_level);
      end
   end

   mcg_cpu_halve u_cpu (
      .clk_in    (REF_CLK_IN),
      .rst_in    (RST_IN),
      .halve_in  (halve_q),
      .tick_in   (mc_tick_d),
      .level_in  (mc_level_d),
      .tick_out  (cpu_tick),
      .level_out (cpu_level)
   );

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign PREADY_OUT   = pready_q;
   assign PRDATA_OUT   = prdata_q;
   assign PSLVERR_OUT  = pslverr_q;
   assign MC_CLK_OUT   = mc_level_q;
   assign MC_TICK_OUT  = mc_tick_q;
   assign CPU_CLK_OUT  = cpu_level;
   assign CPU_TICK_OUT = cpu_tick;
   assign SYS_TICK_OUT = sys_tick_q;
   assign LOCK_OUT     = lock_q;
endmodule

// >>> verif/mcg_osc_model.sv
// Oscillator source model that drives the oscillator pin
`timescale 1ns/100ps
module mcg_osc_model #(
   parameter int HALF_NS = 103  // Half period, inside the allowed range
) (
   input  wire logic en_in,     // Run the oscillator
   output logic      osc_out    // Oscillator level
);
   // Offset by half a ns so no edge lands on a reference clock edge
   initial begin
      osc_out = 1'b0;
      #0.5;
      forever begin
         #(HALF_NS);
         osc_out = en_in ? ~osc_out : 1'b0;
      end
   end
endmodule

// >>> verif/mcg_monitor.sv
// Port checker for the master clock generator
`timescale 1ns/100ps
module mcg_chk
   import mcg_pkg::*;
(
   input wire logic        REF_CLK_IN,   // Clock
   input wire logic        RST_IN,       // Reset
   input wire logic        OSC_IN,       // Osc pin
   input wire logic        PSEL_IN,      // Select
   input wire logic        PENABLE_IN,   // Enable
   input wire logic        PWRITE_IN,    // Direction
   input wire logic [11:0] PADDR_IN,     // Address
   input wire logic [31:0] PWDATA_IN,    // Wdata
   input wire logic        PREADY_OUT,   // Ready
   input wire logic [31:0] PRDATA_OUT,   // Rdata
   input wire logic        PSLVERR_OUT,  // Error
   input wire logic        MC_CLK_OUT,   // Master
   input wire logic        MC_TICK_OUT,  // Master tick
   input wire logic        CPU_CLK_OUT,  // CPU
   input wire logic        CPU_TICK_OUT, // CPU tick
   input wire logic        SYS_TICK_OUT, // Sys tick
   input wire logic        LOCK_OUT      // Locked
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   // ------------------------------------
   // Settings shadow
   // ------------------------------------
   mcg_ctrl_type ctl_q, ctl_d;
   logic         hlv_q, hlv_d, wr, byp, map;
   logic [3:0]   age_q, age_d;
   assign wr  = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
   assign byp = ctl_q.master_clock_source_select != MCG_SRC_PLL;
   assign map = PADDR_IN inside {MCG_CGC_OFFSET, MCG_SC1_OFFSET,
                                 MCG_STAT_OFFSET};
   // Age restarts on a write, so the settling pipeline is not judged
   always_comb begin
      ctl_d = ctl_q;
      hlv_d = hlv_q;
      age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
      if (wr && PADDR_IN == MCG_CGC_OFFSET) begin
         ctl_d = mcg_ctrl_type'(PWDATA_IN[14:0]);
         age_d = 4'h0;
      end
      if (wr && PADDR_IN == MCG_SC1_OFFSET) begin
         hlv_d = PWDATA_IN[MCG_HALVE_BIT];
         age_d = 4'h0;
      end
   end
   // Shadow registers
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctl_q <= mcg_ctrl_type'(MCG_CGC_RESET[14:0]);
         hlv_q <= 1'b0;
         age_q <= 4'h0;
      end else begin
         ctl_q <= ctl_d;
         hlv_q <= hlv_d;
         age_q <= age_d;
      end
   end
   // ------------------------------------
   // Assertions
   // ------------------------------------
   a_ready_wait:
   assert property (PSEL_IN && PENABLE_IN && !$past(PENABLE_IN)
      |-> !PREADY_OUT ##1 PREADY_OUT) else $error("ready wait wrong");
   a_ready_pulse:
   assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready long");
   a_rdata_idle:
   assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000)
      else $error("read data outside ready");
   a_err_map:
   assert property (PREADY_OUT |-> PSLVERR_OUT == !map)
      else $error("error flag vs address wrong");
   a_sys_rate:
   assert property (SYS_TICK_OUT == CPU_TICK_OUT)
      else $error("system tick differs from cpu tick");
   a_cpu_src:
   assert property (CPU_TICK_OUT |-> MC_TICK_OUT)
      else $error("cpu tick without master tick");
   a_cpu_full:
   assert property (age_q == 4'hF && !hlv_q && MC_TICK_OUT |-> CPU_TICK_OUT)
      else $error("cpu tick missing at full rate");
   a_rsvd_quiet:
   assert property (age_q == 4'hF && !byp
      && ctl_q.vco_band_select == MCG_BAND_RSV |-> !MC_TICK_OUT && !LOCK_OUT)
      else $error("reserved band still running");
   a_byp_follow:
   assert property (age_q == 4'hF && byp && ctl_q.input_prescale_factor == 0
      && ctl_q.output_prescale_factor == 0 |-> MC_CLK_OUT == $past(OSC_IN, 3))
      else $error("master does not follow oscillator");
endmodule

// >>> verif/tb_master_clock_generation.sv
// Self-checking bench for the master clock generator
`timescale 1ns/100ps
module tb_master_clock_generation
   import mcg_pkg::*;
   ;
   logic        REF_CLK_IN, RST_IN, OSC_IN, PSEL_IN, PENABLE_IN, PWRITE_IN;
   logic [11:0] PADDR_IN;
   logic [31:0] PWDATA_IN, PRDATA_OUT, rd;
   logic        PREADY_OUT, PSLVERR_OUT, MC_CLK_OUT, MC_TICK_OUT, er;
   logic        CPU_CLK_OUT, CPU_TICK_OUT, SYS_TICK_OUT, LOCK_OUT;
   int          n_mismatch, comparisons;
   mcg_top       u_mcg_top (.*);
   mcg_osc_model u_mcg_osc_model (.en_in(!RST_IN), .osc_out(OSC_IN));
   // ------------------------------------
   // Helpers
   // ------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tmo(input string nm);
      chk(nm, 32'h0000_0001, 32'h0000_0000);
      finish_test();
   endtask
   // One transfer; entered right after a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rdo,
                      output logic err);
      int k;
      PSEL_IN    <= 1'b1;
      PWRITE_IN  <= w;
      PADDR_IN   <= a;
      PWDATA_IN  <= wd;
      @(posedge REF_CLK_IN);
      PENABLE_IN <= 1'b1;
      k = 0;
      do begin
         @(posedge REF_CLK_IN);
         k++;
      end while (PREADY_OUT !== 1'b1 && k < 50);
      if (k == 50) tmo("ready wait");
      rdo = PRDATA_OUT;
      err = PSLVERR_OUT;
      PSEL_IN    <= 1'b0;
      PENABLE_IN <= 1'b0;
      @(posedge REF_CLK_IN);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, rd, er);
      chk(nm, e, rd);
   endtask
   // Counts oscillator rises (or master ticks) between two ticks
   task automatic gap(input logic cpu, output int n);
      int   k, seen;
      logic pv;
      seen = 0;
      n = 0;
      pv = OSC_IN;
      for (k = 0; k < 4000 && seen < 2; k++) begin
         @(posedge REF_CLK_IN);
         if (seen == 1) n += cpu ? int'(MC_TICK_OUT) : int'(OSC_IN && !pv);
         if ((cpu ? CPU_TICK_OUT : MC_TICK_OUT) === 1'b1) seen++;
         pv = OSC_IN;
      end
      if (seen < 2) tmo("tick wait");
   endtask
   // ------------------------------------
   // Scenarios
   // ------------------------------------
   task automatic t_regs();
      rdc("cgc reset", MCG_CGC_OFFSET, MCG_CGC_RESET);
      rdc("sc1 reset", MCG_SC1_OFFSET, MCG_SC1_RESET);
      wr(MCG_CGC_OFFSET, 32'hFFFF_FFFD);
      rdc("cgc limits", MCG_CGC_OFFSET, 32'h0000_7FBD);
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF, rd, er);
      chk("bad wr err", 32'h0000_0001, 32'(er));
      apb(1'b0, 12'h00C, 32'h0000_0000, rd, er);
      chk("bad rd err", 32'h0000_0001, 32'(er));
      chk("bad rd data", 32'h0000_0000, rd);
   endtask
   task automatic t_bypass();
      logic [31:0] cfg [4] = '{32'h0000_0000, 32'h0000_0011,
                               32'h0000_0162, 32'h0000_03B0};
      int          ex [4]  = '{1, 2, 18, 60};
      int          n;
      for (int j = 0; j < 4; j++) begin
         wr(MCG_CGC_OFFSET, cfg[j]);
         gap(1'b0, n);
         gap(1'b0, n);
         chk("bypass div", ex[j], n);
      end
   endtask
   task automatic t_halve();
      int n;
      wr(MCG_CGC_OFFSET, 32'h0000_0010);
      wr(MCG_SC1_OFFSET, 32'h0000_0001);
      gap(1'b1, n);
      gap(1'b1, n);
      chk("cpu halved", 32'h0000_0002, n);
      wr(MCG_SC1_OFFSET, 32'h0000_0000);
      gap(1'b1, n);
      gap(1'b1, n);
      chk("cpu full", 32'h0000_0001, n);
   endtask
   // Bands chosen so the implied rate sits inside each window
   task automatic t_loop();
      logic [31:0] cfg [3] = '{32'h0000_1003, 32'h0000_1807,
                               32'h0000_200B};
      logic [31:0] prv, cur;
      logic [15:0] d;
      int          k, n;
      for (int j = 0; j < 3; j++) begin
         wr(MCG_CGC_OFFSET, 32'h0000_0000);
         wr(MCG_CGC_OFFSET, cfg[j]);
         apb(1'b0, MCG_STAT_OFFSET, 32'h0000_0000, prv, er);
         k = 0;
         do begin
            apb(1'b0, MCG_STAT_OFFSET, 32'h0000_0000, cur, er);
            d = (cur[31:16] > prv[31:16]) ? cur[31:16] - prv[31:16]
                                          : prv[31:16] - cur[31:16];
            chk("fw step", 32'h0000_0001, 32'(d <= MCG_FW_STEP));
            prv = cur;
            k++;
         end while (cur[0] !== 1'b1 && k < 4000);
         chk("loop status", 32'h0000_000B, {LOCK_OUT, cur[2:0]});
         gap(1'b0, n);
         chk("loop gap", 32'h0000_0001, 32'(n <= 1));
      end
      wr(MCG_CGC_OFFSET, 32'h0000_000F);
      repeat (20) @(posedge REF_CLK_IN);
      rdc("rsvd band", MCG_STAT_OFFSET, 32'h6666_0006);
      chk("rsvd flags", 32'h0000_0004, rd & 32'h0000_0005);
   endtask
   // ------------------------------------
   // Clock, reset and sequence
   // ------------------------------------
   initial begin
      REF_CLK_IN = 1'b0;
      forever #10 REF_CLK_IN = ~REF_CLK_IN;
   end
   // Main sequence
   initial begin
      n_mismatch = 0;
      comparisons = 0;
      RST_IN = 1'b1;
      PSEL_IN = 1'b0;
      PENABLE_IN = 1'b0;
      PWRITE_IN = 1'b0;
      PADDR_IN = 12'h000;
      PWDATA_IN = 32'h0000_0000;
      repeat (4) @(posedge REF_CLK_IN);
      RST_IN <= 1'b0;
      t_regs();
      t_bypass();
      t_halve();
      t_loop();
      finish_test();
   end
endmodule

bind mcg_top mcg_chk u_mcg_chk (.*);
